// ===== design/emp_bus_ctrl.sv
`timescale 1ns/1ps
`include "emp_map.svh"

module emp_bus_ctrl
    import emp_pkg::*;
(
    input  wire logic        mclk,                     // system clock
    input  wire logic        rst_b,                    // async reset, active low
    input  wire logic        cyc_start,                // pulse: begin a cycle
    input  wire logic [1:0]  cyc_kind,                 // emp_kind_t of the cycle
    input  wire logic        cyc_internal,             // fetch served on chip
    input  wire logic        cyc_write,                // data move is a write
    input  wire logic [15:0] cyc_addr,                 // cycle address
    input  wire logic [7:0]  cyc_wdata,                // write data
    input  wire logic        lo_port_wr,               // core writes low latch
    input  wire logic        hi_port_wr,               // core writes high latch
    input  wire logic [7:0]  port_wdata,               // latch write value
    input  wire logic [7:0]  ad_in,                    // low port pin levels
    output logic [7:0]       ad_out,                   // low port drive value
    output logic [7:0]       ad_oe_n,                  // low port enables, low drives
    output logic [7:0]       hi_pin,                   // high port pin value
    output logic             ale,                      // address latch enable
    output logic             program_fetch_strobe_n,   // fetch read strobe
    output logic             rd_n,                     // data read strobe
    output logic             wr_n,                     // data write strobe
    output logic [7:0]       low_addr_data_port,       // low latch contents
    output logic [7:0]       high_addr_port,           // high latch contents
    output logic [7:0]       rdata,                    // read data
    output logic             busy,                     // cycle in progress
    output logic             done                      // pulse: cycle finished
);

    emp_state_t state_q;
    emp_kind_t  kind_q;
    logic       wr_q;
    logic [7:0] wdata_q;
    logic [2:0] cnt_q;
    logic [7:0] lo_lat_q;
    logic [7:0] hi_lat_q;
    logic [7:0] hi_save_q;
    logic [7:0] ad_out_q;
    logic [7:0] ad_oe_n_q;
    logic [7:0] hi_pin_q;
    logic       ale_q;
    logic       pfs_n_q;
    logic       rd_n_q;
    logic       wr_n_q;
    logic [7:0] rdata_q;
    logic       done_q;
    logic       busy_q;
    logic       idle;
    logic       int_fetch;
    logic       go_addr;
    logic       go_strb;
    logic       go_end;
    logic       go_idle;

    // phase transitions shared by the processes below
    assign idle      = (state_q == EMP_ST_IDLE);
    assign int_fetch = cyc_internal && (cyc_kind == EMP_FETCH);
    assign go_addr   = idle && cyc_start && !int_fetch;
    assign go_strb   = (state_q == EMP_ST_ADDR);
    assign go_end    = (state_q == EMP_ST_STRB) && (cnt_q == 3'd0);
    assign go_idle   = (state_q == EMP_ST_END);

    // sequencer: address phase, strobe phase, wrap-up
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= EMP_ST_IDLE;
            kind_q  <= EMP_FETCH;
            wr_q    <= 1'b0;
            wdata_q <= 8'h00;
            cnt_q   <= 3'd0;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                EMP_ST_IDLE: begin
                    if (go_addr) begin
                        state_q <= EMP_ST_ADDR;
                        kind_q  <= emp_kind_t'(cyc_kind);
                        wr_q    <= cyc_write && (cyc_kind != EMP_FETCH);
                        wdata_q <= cyc_wdata;
                        busy_q  <= 1'b1;         // registered twin of state != idle
                    end else if (cyc_start) begin
                        done_q <= 1'b1;          // internal fetch, no bus activity
                    end
                end
                EMP_ST_ADDR: begin
                    state_q <= EMP_ST_STRB;
                    cnt_q   <= `EMP_STRB_CYC - 3'd1;
                end
                EMP_ST_STRB: begin
                    cnt_q <= cnt_q - 3'd1;
                    if (go_end) begin
                        state_q <= EMP_ST_END;
                    end
                end
                EMP_ST_END: begin
                    state_q <= EMP_ST_IDLE;
                    done_q  <= 1'b1;
                    busy_q  <= 1'b0;
                end
                default: begin
                    state_q <= EMP_ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // low latch: any external cycle overwrites it with ones
    // core writes only land while idle; the bus owns it otherwise
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lo_lat_q <= `EMP_LO_RST;
        end else if (go_addr) begin
            lo_lat_q <= `EMP_ALL_ONES;
        end else if (idle && !cyc_start && lo_port_wr) begin
            lo_lat_q <= port_wdata;
        end
    end

    // high latch: fetch sets ones for good, wide move borrows it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hi_lat_q  <= `EMP_HI_RST;
            hi_save_q <= `EMP_HI_RST;
        end else if (go_addr) begin
            if (cyc_kind == EMP_FETCH) begin
                hi_lat_q <= `EMP_ALL_ONES;
            end else if (cyc_kind == EMP_WIDE) begin
                hi_save_q <= hi_lat_q;
                hi_lat_q  <= `EMP_ALL_ONES;
            end
            // narrow move leaves it alone, port stays usable as gpio
        end else if (go_idle && kind_q == EMP_WIDE) begin
            hi_lat_q <= hi_save_q;
        end else if (idle && !cyc_start && hi_port_wr) begin
            hi_lat_q <= port_wdata;
        end
    end

    // pin drivers, all registered so the outputs never glitch
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ad_out_q  <= 8'h00;
            ad_oe_n_q <= `EMP_AD_RELEASE;
            hi_pin_q  <= `EMP_HI_RST;
            ale_q     <= 1'b0;
            pfs_n_q   <= 1'b1;
            rd_n_q    <= 1'b1;
            wr_n_q    <= 1'b1;
            rdata_q   <= 8'h00;
        end else if (go_addr) begin
            ale_q     <= 1'b1;
            ad_out_q  <= cyc_addr[7:0];
            ad_oe_n_q <= 8'h00;
            // narrow move puts the latch, not the address, on the high port
            hi_pin_q  <= (cyc_kind == EMP_NARROW) ? hi_lat_q : cyc_addr[15:8];
        end else if (go_strb) begin
            ale_q <= 1'b0;
            if (wr_q) begin
                ad_out_q  <= wdata_q;
                ad_oe_n_q <= 8'h00;
                wr_n_q    <= 1'b0;
            end else begin
                ad_oe_n_q <= `EMP_AD_RELEASE;           // let the memory drive
                if (kind_q == EMP_FETCH) begin
                    pfs_n_q <= 1'b0;
                end else begin
                    rd_n_q <= 1'b0;
                end
            end
        end else if (go_end) begin
            // sample before strobes rise: memory floats after enables drop
            if (!wr_q) begin
                rdata_q <= ad_in;
            end
            pfs_n_q <= 1'b1;
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
        end else if (idle || go_idle) begin
            // open drain: a zero latch bit pulls low, a one releases
            ad_out_q  <= 8'h00;
            ad_oe_n_q <= go_idle ? `EMP_ALL_ONES : lo_lat_q;
            hi_pin_q  <= (go_idle && kind_q == EMP_WIDE) ? hi_save_q : hi_lat_q;
        end
    end

    assign ad_out                 = ad_out_q;
    assign ad_oe_n                = ad_oe_n_q;
    assign hi_pin                 = hi_pin_q;
    assign ale                    = ale_q;
    assign program_fetch_strobe_n = pfs_n_q;
    assign rd_n                   = rd_n_q;
    assign wr_n                   = wr_n_q;
    assign low_addr_data_port     = lo_lat_q;
    assign high_addr_port         = hi_lat_q;
    assign rdata                  = rdata_q;
    assign busy                   = busy_q;
    assign done                   = done_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    chk_lo_ones_busy: assert property (
        (state_q != EMP_ST_IDLE) |-> (lo_lat_q == 8'hff) ##1 (lo_lat_q == 8'hff))
        else $error("low latch not all ones around external cycle");

    chk_fetch_hi_ones: assert property (
        (go_addr && cyc_kind == EMP_FETCH) |=> (hi_lat_q == 8'hff) [*6])
        else $error("high latch not all ones during or after fetch");

    chk_narrow_hi_kept: assert property (
        (go_addr && cyc_kind == EMP_NARROW) |=> ($stable(hi_lat_q)) [*5])
        else $error("narrow move disturbed high latch");

    chk_narrow_hi_pin: assert property (
        (go_addr && cyc_kind == EMP_NARROW) |=> (hi_pin_q == $past(hi_lat_q)))
        else $error("narrow move drove address on high port");

    chk_wide_hi_ones: assert property (
        (state_q == EMP_ST_STRB && kind_q == EMP_WIDE) |-> (hi_lat_q == 8'hff))
        else $error("high latch not all ones during wide move");

    chk_wide_hi_back: assert property (
        (go_addr && cyc_kind == EMP_WIDE) |-> ##6 (hi_lat_q == $past(hi_lat_q, 6)))
        else $error("high latch not restored after wide move");

    chk_strobe_fetch_only: assert property (
        !pfs_n_q |-> (state_q == EMP_ST_STRB && kind_q == EMP_FETCH && !wr_q))
        else $error("fetch strobe outside external fetch");

    chk_internal_quiet: assert property (
        (idle && cyc_start && int_fetch) |=> pfs_n_q && idle && done_q)
        else $error("internal fetch touched the bus");

endmodule

// ===== design/emp_map.svh
`ifndef EMP_MAP_SVH
`define EMP_MAP_SVH

// value the low latch takes during and after external cycles, the high latch during fetches and wide moves and after fetches
`define EMP_ALL_ONES    8'hff
// reset value of both port latches
`define EMP_LO_RST      8'hff
`define EMP_HI_RST      8'hff
// all pins of the low port released
`define EMP_AD_RELEASE  8'hff
// strobe phase length in mclk cycles (address phase is always one)
`define EMP_STRB_CYC    3'd3

`endif

// ===== design/emp_pkg.sv
package emp_pkg;

    // kind of external cycle asked for by the core
    typedef enum logic [1:0] {
        EMP_FETCH  = 2'b00,  // instruction fetch, 16-bit address
        EMP_NARROW = 2'b01,  // external_data_move via narrow_index_register
        EMP_WIDE   = 2'b10   // external_data_move via wide_data_pointer
    } emp_kind_t;

    // bus sequencer states
    typedef enum logic [1:0] {
        EMP_ST_IDLE = 2'b00,
        EMP_ST_ADDR = 2'b01,
        EMP_ST_STRB = 2'b10,
        EMP_ST_END  = 2'b11
    } emp_state_t;

endpackage

// ===== tb/emp_eprom_model.sv
`timescale 1ns/1ps

// byte-wide memory behind an address latch strobed by ale
module emp_eprom_model (
    input  wire logic       mclk,    // system clock, for the latch
    input  wire logic       ale,     // address latch enable
    input  wire logic       ce_n,    // chip enable, active low
    input  wire logic       oe_n,    // output enable, active low
    input  wire logic [7:0] bus,     // low port wire level
    input  wire logic [7:0] hi_pin,  // high address lines
    output logic [7:0]      q,       // data output value
    output logic            drive    // high while outputs drive
);
    logic [7:0] mem [0:65535];
    logic [7:0] lo_q;

    // contents derived from the address so the bench can predict them
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
    end

    // external latch holds the low address after ale falls
    always @(posedge mclk) begin
        if (ale) lo_q <= bus;
    end

    // released outputs float, the pull-ups of the bench take the wire
    assign drive = !ce_n && !oe_n;
    assign q     = mem[{hi_pin, lo_q}];
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end

module testbench
    import emp_pkg::*;
;
    typedef struct {
        logic [1:0]  k;
        logic        in;
        logic        wr;
        logic [15:0] a;
        logic [7:0]  wd, hd, ha, pin, rd;
    } emp_row_t;
    logic mclk = 0, rst_b = 0, cyc_start = 0, cyc_internal = 0, cyc_write = 0, ce_n = 0;
    logic lo_port_wr = 0, hi_port_wr = 0, ale, program_fetch_strobe_n, rd_n, wr_n, busy, done;
    logic mem_drive;
    logic [1:0]  cyc_kind = 2'h0;
    logic [15:0] cyc_addr = 16'h0000;
    logic [7:0]  cyc_wdata = 8'h00, port_wdata = 8'h00, ad_in, ad_out, ad_oe_n, hi_pin, mem_q;
    logic [7:0]  low_addr_data_port, high_addr_port, rdata, dur_hi, dur_pin, wr_seen;
    int n_fail = 0, check_count = 0, n_ps = 0, n_rd = 0, n_wr = 0, p0, r0, w0;
    // high latch preset to 3c, so kept and restored values stand apart from ff
    // wide rows stand for big-RAM software, which keeps to pointer moves
    emp_row_t rows [6] = '{
        '{EMP_NARROW, 0, 0, 16'h1234, 8'h00, 8'h3c, 8'h3c, 8'h3c, 8'hff},
        '{EMP_FETCH,  1, 0, 16'h0042, 8'h00, 8'h3c, 8'h3c, 8'h3c, 8'hff},
        '{EMP_WIDE,   0, 0, 16'h8001, 8'h00, 8'hff, 8'h3c, 8'h80, 8'hff},
        '{EMP_WIDE,   0, 1, 16'hfffe, 8'h77, 8'hff, 8'h3c, 8'hff, 8'hff},
        '{EMP_NARROW, 0, 1, 16'h00a0, 8'h81, 8'h3c, 8'h3c, 8'h3c, 8'hff},
        '{EMP_FETCH,  0, 0, 16'ha55a, 8'h00, 8'hff, 8'hff, 8'ha5, 8'ha5}};

    // pulled-up low port: design drive first, then memory, else ones
    assign ad_in = (~ad_oe_n & ad_out) | (ad_oe_n & (mem_drive ? mem_q : 8'hff));

    emp_bus_ctrl emp_bus_ctrl_inst (.mclk(mclk), .rst_b(rst_b), .cyc_start(cyc_start),
        .cyc_kind(cyc_kind), .cyc_internal(cyc_internal), .cyc_write(cyc_write),
        .cyc_addr(cyc_addr), .cyc_wdata(cyc_wdata), .lo_port_wr(lo_port_wr),
        .hi_port_wr(hi_port_wr), .port_wdata(port_wdata), .ad_in(ad_in), .ad_out(ad_out),
        .ad_oe_n(ad_oe_n), .hi_pin(hi_pin), .ale(ale),
        .program_fetch_strobe_n(program_fetch_strobe_n), .rd_n(rd_n), .wr_n(wr_n),
        .low_addr_data_port(low_addr_data_port), .high_addr_port(high_addr_port),
        .rdata(rdata), .busy(busy), .done(done));

    // memory output enable follows the fetch strobe
    emp_eprom_model emp_eprom_model_inst (.mclk(mclk), .ale(ale), .ce_n(ce_n),
        .oe_n(program_fetch_strobe_n), .bus(ad_in), .hi_pin(hi_pin), .q(mem_q),
        .drive(mem_drive));

    initial begin
        forever #5 mclk = ~mclk;
    end

    // strobe cycle counters
    always @(posedge mclk) begin
        n_ps <= n_ps + int'(program_fetch_strobe_n === 1'b0);
        n_rd <= n_rd + int'(rd_n === 1'b0);
        n_wr <= n_wr + int'(wr_n === 1'b0);
        // byte seen on the wire while the write strobe is low
        if (wr_n === 1'b0) wr_seen <= ad_in;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // one bus cycle; snapshot of the high side taken in the address phase
    // b2b raises the request at once, in the done cycle of the call before
    task automatic do_cyc(input emp_row_t r, input bit b2b = 1'b0);
        if (!b2b) begin
            @(posedge mclk) #1;
        end
        {cyc_kind, cyc_internal, cyc_write, cyc_addr, cyc_wdata} = {r.k, r.in, r.wr, r.a, r.wd};
        cyc_start = 1;
        p0 = n_ps; r0 = n_rd; w0 = n_wr;
        @(posedge mclk) #1;
        cyc_start = 0;
        dur_hi = high_addr_port;
        dur_pin = hi_pin;
        `CHK(busy, !(r.k == EMP_FETCH && r.in))
        for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge mclk) #1;
        `CHK(done, 1'b1)
    endtask

    initial begin
        #20000;
        n_fail++;
        close_out;
    end

    initial begin
        repeat (3) @(posedge mclk);
        #1 rst_b = 1;
        `CHK({low_addr_data_port, high_addr_port, busy}, {8'hff, 8'hff, 1'b0})
        hi_port_wr = 1;
        port_wdata = 8'h3c;
        @(posedge mclk) #1 hi_port_wr = 0;
        // low latch written while idle shows on the open-drain enables
        lo_port_wr = 1;
        port_wdata = 8'h0f;
        @(posedge mclk) #1 lo_port_wr = 0;
        @(posedge mclk) #1;
        `CHK({low_addr_data_port, ad_oe_n}, {8'h0f, 8'h0f})
        foreach (rows[n]) begin
            do_cyc(rows[n]);
            `CHK(dur_hi, rows[n].hd)
            `CHK(dur_pin, rows[n].pin)
            `CHK(high_addr_port, rows[n].ha)
            `CHK(hi_pin, rows[n].ha)
            `CHK(low_addr_data_port, 8'hff)
            `CHK(rdata, rows[n].rd)
            `CHK(n_ps - p0, (rows[n].k == EMP_FETCH && !rows[n].in) ? 3 : 0)
            `CHK(n_rd - r0, (rows[n].k != EMP_FETCH && !rows[n].wr) ? 3 : 0)
            `CHK(n_wr - w0, (rows[n].k != EMP_FETCH && rows[n].wr) ? 3 : 0)
            if (rows[n].wr) `CHK(wr_seen, rows[n].wd)
        end
        // memory in standby: fetched byte is the pulled-up level
        ce_n = 1;
        do_cyc(rows[5]);
        `CHK(rdata, 8'hff)
        ce_n = 0;
        // back to back fetch issued in the done cycle
        do_cyc('{EMP_FETCH, 0, 0, 16'h0103, 8'h00, 8'hff, 8'hff, 8'h01, 8'h58}, 1'b1);
        `CHK(rdata, 8'h58)
        `CHK(n_ps - p0, 3)
        // reset dropped while a fetch strobe is low
        @(posedge mclk) #1 cyc_start = 1;
        @(posedge mclk) #1 cyc_start = 0;
        @(posedge mclk) #1 rst_b = 0;
        #1;
        `CHK({program_fetch_strobe_n, busy, rdata}, {1'b1, 1'b0, 8'h00})
        `CHK({low_addr_data_port, high_addr_port, hi_pin}, {8'hff, 8'hff, 8'hff})
        @(posedge mclk) #1 rst_b = 1;
        // the bus comes back clean after the cut cycle
        do_cyc(rows[5]);
        `CHK(rdata, 8'ha5)
        `CHK(n_ps - p0, 3)
        close_out;
    end
endmodule
